// file: shared/tsc_pkg.sv
// shared constants and types for the traffic signal coordinator
package tsc_pkg;
   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned TICK_MS       = 1000;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned NUM_CYCLES    = 4;
   localparam int unsigned NUM_OFFSETS   = 3;
   localparam int unsigned NUM_EVENTS    = 100;
   localparam int unsigned NUM_DST       = 2;
   localparam int unsigned PCT_FULL      = 100;
   localparam logic [7:0]  CYC_LEN_RST0  = 8'h3c;
   localparam logic [7:0]  CYC_LEN_RST1  = 8'h50;
   localparam logic [7:0]  CYC_LEN_RST2  = 8'h64;
   localparam logic [7:0]  CYC_LEN_RST3  = 8'h78;
   localparam logic [6:0]  SPLIT_RST     = 7'h32;
   localparam logic [6:0]  OFFSET_RST    = 7'h00;
   localparam logic [6:0]  PERMIT_RST    = 7'h0a;
   localparam logic [5:0]  INTERRUPT_MAX = 6'h28;
   localparam logic [1:0]  CYCLE_DEFAULT = 2'h0;
   localparam logic [1:0]  OFFSET_DEFAULT = 2'h0;

   typedef enum logic [3:0] {
      TSC_FREE     = 4'b0001,
      TSC_WAIT     = 4'b0010,
      TSC_COORD    = 4'b0100,
      TSC_SPECIAL  = 4'b1000
   } tsc_mode_type;

   typedef struct packed {
      logic [7:0] cycle_len;
      logic [6:0] split_pct;
      logic [6:0] sync_pct;
      logic [6:0] offset_pct0;
      logic [6:0] offset_pct1;
      logic [6:0] offset_pct2;
   } tsc_plan_type;

   typedef struct packed {
      logic [1:0]  cycle_sel;
      logic [1:0]  offset_sel;
      logic        free_req;
      logic        sync;
      logic        valid;
      logic        conflict;
   } tsc_master_type;

   typedef struct packed {
      logic       sync;
      logic       yield;
      logic       force_off;
      logic       free_run;
      logic       max_inhibit;
      logic       phase_omit;
      logic       aux_flash;
      logic       second_maximum_select;
   } tsc_out_type;
endpackage

// file: verilog/tsc_coordinator.sv
// time base coordinator: cycle timer, plan selection, yield and force-off outputs
module tsc_coordinator #(
   parameter int unsigned TICK_CYCLES = tsc_pkg::TICK_CYCLES,
   parameter int unsigned NUM_PHASES  = 8
) (
   input  wire logic                         REF_CLK,
   input  wire logic                         RST_N,
   input  wire logic                         COORD_SEL,
   input  wire logic [1:0]                   PANEL_CYCLE,
   input  wire tsc_pkg::tsc_master_type      MASTER,
   input  wire logic                         TOD_USE,
   input  wire logic [1:0]                   TOD_CYCLE,
   input  wire logic [1:0]                   TOD_OFFSET,
   input  wire logic                         TOD_FREE,
   input  wire logic                         SPECIAL_OP,
   input  wire logic                         PHASE_A_END,
   input  wire logic                         DWELL,
   input  wire logic                         INTERRUPT_EN,
   input  wire logic [5:0]                   INTERRUPT_SEC,
   input  wire logic [7:0]                   AUX_END_PCT,
   input  wire logic                         PLAN_WR,
   input  wire logic [1:0]                   PLAN_WR_IDX,
   input  wire tsc_pkg::tsc_plan_type        PLAN_WR_DATA,
   input  wire logic [6:0]                   PERMIT_PCT,
   input  wire logic [NUM_PHASES-1:0]        PHASE_OMIT_CFG,
   input  wire logic [2:0]                   AUX_CFG,
   output tsc_pkg::tsc_out_type              OUTS,
   output logic                              AUX_MOVE_END,
   output logic                              PERMIT,
   output logic [NUM_PHASES-1:0]             PHASE_OMIT,
   output logic [2:0]                        AUX_OUT,
   output logic [2:0]                        SYNC_LAMP,
   output logic [7:0]                        CYCLE_COUNT,
   output logic [1:0]                        ACTIVE_CYCLE,
   output logic [1:0]                        ACTIVE_OFFSET,
   output logic                              IN_STEP,
   output logic                              ENTRY_ACK
);
   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

   tsc_pkg::tsc_plan_type plan_q [tsc_pkg::NUM_CYCLES];
   tsc_pkg::tsc_mode_type mode_q;
   tsc_pkg::tsc_mode_type mode_d;
   logic [TW-1:0]         tick_cnt_q;
   logic [7:0]            cyc_cnt_q;
   logic [1:0]            cyc_q;
   logic [1:0]            off_q;
   logic [5:0]            dwell_sec_q;
   logic                  in_step_q;
   tsc_pkg::tsc_out_type  outs_q;
   logic                  aux_end_q;
   logic                  permit_q;
   logic [NUM_PHASES-1:0] omit_q;
   logic [2:0]            aux_q;
   logic [2:0]            lamp_q;
   logic                  ack_q;

   function automatic logic [7:0] pct_to_sec(input logic [7:0] len, input logic [6:0] pct);
      logic [15:0] prod;
      prod = 16'(len) * 16'(pct);
      return 8'(prod / 16'(tsc_pkg::PCT_FULL));
   endfunction

   // tick and selection decode
   wire        sec_tick     = (tick_cnt_q == TW'(TICK_CYCLES - 1));
   wire        master_bad   = !MASTER.valid || MASTER.conflict;
   // missing master data falls to the panel, which acts as the standby cycle
   wire        master_fault = MASTER.valid && MASTER.conflict;
   wire [1:0]  cyc_src      = TOD_USE ? TOD_CYCLE : (MASTER.valid ? MASTER.cycle_sel : PANEL_CYCLE);
   wire [1:0]  off_src      = TOD_USE ? TOD_OFFSET : MASTER.offset_sel;
   wire [1:0]  cyc_want     = (!TOD_USE && master_fault) ? tsc_pkg::CYCLE_DEFAULT : cyc_src;
   wire [1:0]  off_want     = (!TOD_USE && master_fault) ? tsc_pkg::OFFSET_DEFAULT : off_src;
   wire        cyc_want_ok  = (cyc_want != 2'h3) || TOD_USE; // panel and master select one of three
   wire        free_want    = !COORD_SEL || (TOD_USE ? TOD_FREE : MASTER.free_req);
   wire [7:0]  cur_len      = plan_q[cyc_q].cycle_len;
   wire [6:0]  cur_off_pct  = (off_q == 2'h2) ? plan_q[cyc_q].offset_pct2 :
                              (off_q == 2'h1) ? plan_q[cyc_q].offset_pct1 : plan_q[cyc_q].offset_pct0;
   wire [7:0]  split_pt     = pct_to_sec(cur_len, plan_q[cyc_q].split_pct);
   wire [7:0]  permit_end   = pct_to_sec(cur_len, PERMIT_PCT);
   wire [7:0]  off_pt       = pct_to_sec(cur_len, cur_off_pct);
   wire [7:0]  aux_pt       = pct_to_sec(cur_len, AUX_END_PCT[6:0]);
   wire [7:0]  cyc_next     = (cyc_cnt_q + 8'h01 >= cur_len) ? 8'h00 : cyc_cnt_q + 8'h01;
   wire        master_sync  = MASTER.sync && !master_bad;
   wire        coord_mode   = (mode_q == tsc_pkg::TSC_COORD);
   wire        sync_pulse   = coord_mode && sec_tick && (cyc_cnt_q == off_pt);
   wire        yield_pt     = sec_tick && (cyc_cnt_q == 8'h00);
   wire        change_ok    = PHASE_A_END || yield_pt;
   wire [5:0]  int_lim      = (INTERRUPT_SEC > tsc_pkg::INTERRUPT_MAX) ? tsc_pkg::INTERRUPT_MAX : INTERRUPT_SEC;
   wire        dwell_cap    = INTERRUPT_EN && !in_step_q && DWELL && (dwell_sec_q >= int_lim);
   wire        force_now    = coord_mode && (cyc_cnt_q == split_pt || dwell_cap);
   wire        yield_now    = coord_mode && (cyc_cnt_q < permit_end);
   wire        aux_now      = coord_mode && (cyc_cnt_q == aux_pt) && (AUX_END_PCT[7] == 1'b0);

   // mode sequencing
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         tsc_pkg::TSC_FREE: begin
            if (!free_want && !SPECIAL_OP) mode_d = tsc_pkg::TSC_WAIT;
         end
         tsc_pkg::TSC_WAIT: begin
            if (free_want) mode_d = tsc_pkg::TSC_FREE;
            else if (change_ok) mode_d = tsc_pkg::TSC_COORD;
         end
         tsc_pkg::TSC_COORD: begin
            if (free_want) mode_d = tsc_pkg::TSC_FREE;
            else if (SPECIAL_OP) mode_d = tsc_pkg::TSC_SPECIAL;
         end
         tsc_pkg::TSC_SPECIAL: begin
            if (!SPECIAL_OP) mode_d = free_want ? tsc_pkg::TSC_FREE : tsc_pkg::TSC_COORD;
         end
         default: mode_d = tsc_pkg::TSC_FREE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= tsc_pkg::TSC_FREE;
      end else begin
         mode_q <= mode_d;
      end
   end

   // second tick and background cycle count keep running in every mode
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt_q <= '0;
         cyc_cnt_q  <= 8'h00;
      end else begin
         tick_cnt_q <= sec_tick ? '0 : tick_cnt_q + TW'(1);
         if (sec_tick) cyc_cnt_q <= cyc_next;
      end
   end

   // plan store, written from the keypad path
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         plan_q[0] <= '{tsc_pkg::CYC_LEN_RST0, tsc_pkg::SPLIT_RST, tsc_pkg::OFFSET_RST,
                        tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST};
         plan_q[1] <= '{tsc_pkg::CYC_LEN_RST1, tsc_pkg::SPLIT_RST, tsc_pkg::OFFSET_RST,
                        tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST};
         plan_q[2] <= '{tsc_pkg::CYC_LEN_RST2, tsc_pkg::SPLIT_RST, tsc_pkg::OFFSET_RST,
                        tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST};
         plan_q[3] <= '{tsc_pkg::CYC_LEN_RST3, tsc_pkg::SPLIT_RST, tsc_pkg::OFFSET_RST,
                        tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST, tsc_pkg::OFFSET_RST};
         ack_q     <= 1'b0;
      end else begin
         // out-of-range split percentages and zero lengths are refused, no ack
         ack_q <= 1'b0;
         if (PLAN_WR && PLAN_WR_DATA.cycle_len != 8'h00 && PLAN_WR_DATA.split_pct <= 7'(tsc_pkg::PCT_FULL)) begin
            plan_q[PLAN_WR_IDX] <= PLAN_WR_DATA;
            ack_q               <= 1'b1;
         end
      end
   end

   // plan selection changes freely outside coordination, and in coordination only at the yield point or phase A end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cyc_q <= tsc_pkg::CYCLE_DEFAULT;
         off_q <= tsc_pkg::OFFSET_DEFAULT;
      end else if ((change_ok || !coord_mode) && cyc_want_ok) begin
         cyc_q <= cyc_want;
         off_q <= (off_want == 2'h3) ? tsc_pkg::OFFSET_DEFAULT : off_want;
      end
   end

   // in-step tracking and dwell interrupter
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         in_step_q   <= 1'b0;
         dwell_sec_q <= 6'h00;
      end else begin
         if (master_sync) in_step_q <= (cyc_cnt_q == off_pt);
         else if (master_bad || SPECIAL_OP) in_step_q <= 1'b0;
         if (!DWELL) dwell_sec_q <= 6'h00;
         else if (sec_tick && dwell_sec_q != 6'h3f) dwell_sec_q <= dwell_sec_q + 6'h01;
      end
   end

   // registered outputs toward the local controller
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         outs_q    <= '0;
         aux_end_q <= 1'b0;
         permit_q  <= 1'b0;
         omit_q    <= '0;
         aux_q     <= 3'h0;
         lamp_q    <= 3'h0;
      end else begin
         outs_q.sync                  <= sync_pulse;
         outs_q.yield                 <= yield_now;
         outs_q.force_off             <= force_now;
         outs_q.free_run              <= !coord_mode;
         outs_q.max_inhibit           <= coord_mode;
         outs_q.phase_omit            <= coord_mode && (|PHASE_OMIT_CFG);
         outs_q.aux_flash             <= AUX_CFG[0];
         outs_q.second_maximum_select <= AUX_CFG[1];
         aux_end_q                    <= aux_now;
         permit_q                     <= yield_now;
         omit_q                       <= coord_mode ? PHASE_OMIT_CFG : '0;
         aux_q                        <= AUX_CFG;
         lamp_q                       <= coord_mode ? (3'h1 << cyc_q) : 3'h0;
      end
   end

   assign OUTS          = outs_q;
   assign AUX_MOVE_END  = aux_end_q;
   assign PERMIT        = permit_q;
   assign PHASE_OMIT    = omit_q;
   assign AUX_OUT       = aux_q;
   assign SYNC_LAMP     = lamp_q;
   assign CYCLE_COUNT   = cyc_cnt_q;
   assign ACTIVE_CYCLE  = cyc_q;
   assign ACTIVE_OFFSET = off_q;
   assign IN_STEP       = in_step_q;
   assign ENTRY_ACK     = ack_q;

   // checks
   sequence wait_then_yield_s;
      (mode_q == tsc_pkg::TSC_WAIT) ##0 change_ok;
   endsequence

   free_out_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !coord_mode |=> outs_q.free_run) else $error("free output not asserted outside coordination");
   max_inhibit_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      coord_mode |=> outs_q.max_inhibit) else $error("internal max not inhibited when coordinated");
   transfer_yield_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (mode_q == tsc_pkg::TSC_WAIT && !change_ok && !free_want) |=> mode_q == tsc_pkg::TSC_WAIT)
      else $error("transfer outside yield point");
   transfer_go_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      wait_then_yield_s ##0 !free_want |=> coord_mode) else $error("transfer missed at yield point");
   fallback_sel_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (!TOD_USE && master_fault && !coord_mode) |=> cyc_q == 2'h0 && off_q == 2'h0)
      else $error("no fallback to cycle one");
   timer_runs_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (sec_tick && SPECIAL_OP) |=> cyc_cnt_q == $past(cyc_next)) else $error("cycle timer stalled");
   sync_only_coord_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !COORD_SEL ##1 !COORD_SEL |=> !outs_q.sync) else $error("sync while free selected");
   dwell_cap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      dwell_cap && coord_mode |=> outs_q.force_off) else $error("dwell not limited by interrupter");
   lamp_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      coord_mode |=> $onehot(lamp_q)) else $error("sync lamp not one-hot when coordinated");
   ack_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      PLAN_WR && PLAN_WR_DATA.cycle_len != 8'h00 && PLAN_WR_DATA.split_pct <= 7'(tsc_pkg::PCT_FULL) |=> ENTRY_ACK)
      else $error("accepted entry not acknowledged");

   // output timing checks, one cycle behind the decode, plus same-cycle range checks on off_q and int_lim
   sequence coord_yield_s;
      coord_mode ##0 yield_now;
   endsequence

   force_split_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      coord_mode && cyc_cnt_q == split_pt |=> outs_q.force_off) else $error("no force-off at split point");

   aux_end_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      aux_now |=> aux_end_q) else $error("auxiliary end missed");

   aux_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      AUX_END_PCT[7] |=> !aux_end_q) else $error("auxiliary end while disabled");

   permit_follow_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      coord_yield_s |=> permit_q && outs_q.yield) else $error("permissive window not shown");

   cycle_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      sec_tick && cyc_next == 8'h00 |=> cyc_cnt_q == 8'h00) else $error("cycle count did not wrap");

   sync_point_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      sync_pulse |=> outs_q.sync) else $error("sync pulse missed at offset point");

   lamp_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !coord_mode |=> lamp_q == 3'h0) else $error("sync lamp lit outside coordination");

   off_three_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      off_q != 2'h3) else $error("unused offset selection taken");

   max_free_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !coord_mode |=> !outs_q.max_inhibit) else $error("internal max inhibited outside coordination");

   int_clamp_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      int_lim <= tsc_pkg::INTERRUPT_MAX) else $error("interrupter limit above range");

   dwell_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !DWELL |=> dwell_sec_q == 6'h00) else $error("dwell timer not restarted");

   no_cap_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      coord_mode && !INTERRUPT_EN && cyc_cnt_q != split_pt |=> !outs_q.force_off)
      else $error("force-off while interrupter switched out");

   special_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      mode_q == tsc_pkg::TSC_SPECIAL && SPECIAL_OP |=> mode_q == tsc_pkg::TSC_SPECIAL)
      else $error("special operation left early");

   omit_free_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !coord_mode |=> omit_q == '0) else $error("phase omit outside coordination");

   refuse_entry_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !PLAN_WR || PLAN_WR_DATA.cycle_len == 8'h00 |=> !ENTRY_ACK) else $error("refused entry acknowledged");

   // a tick lasts one clock, so the second count never double steps
   tick_single_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      sec_tick |=> !sec_tick) else $error("second tick longer than one clock");
endmodule

// file: tb/tsc_ctrl_model.sv
// behavioural local actuated controller facing the coordinator
module tsc_ctrl_model (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire tsc_pkg::tsc_out_type outs,
   input  wire logic                 yield_req,
   input  wire logic                 dwell_req,
   output logic                      phase_a_end,
   output logic                      dwell,
   output logic                      internal_max_on,
   output logic                      free_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   assign internal_max_on = !outs.max_inhibit;
   assign free_mode       = outs.free_run;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_a_end <= 1'b0;
         dwell       <= 1'b0;
      end else begin
         phase_a_end <= yield_req;
         // a force-off ends the dwell on the next clock, as a real controller would
         dwell       <= dwell_req & ~outs.force_off;
      end
   end
endmodule

// file: tb/tsc_coordinator_tb_top.sv
// self-checking bench for the coordinator with a behavioural controller
module tsc_coordinator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICKS = 10;   // shortened second keeps the run brief
   logic                    ref_clk, rst_n, coord_sel, tod_use, tod_free, special_op;
   logic                    yield_req, dwell_req, interrupt_en, plan_wr, phase_a_end, dwell;
   logic                    aux_move_end, permit, in_step, entry_ack, ctrl_max_on, ctrl_free;
   logic [1:0]              panel_cycle, tod_cycle, tod_offset, plan_wr_idx, active_cycle, active_offset;
   logic [5:0]              interrupt_sec;
   logic [6:0]              permit_pct;
   logic [7:0]              aux_end_pct, omit_cfg, phase_omit, cycle_count;
   logic [2:0]              aux_cfg, aux_out, sync_lamp;
   tsc_pkg::tsc_master_type master;
   tsc_pkg::tsc_plan_type   plan_data;
   tsc_pkg::tsc_out_type    outs;
   int                      failures = 0;
   int                      compares = 0;
   int                      cycles = 0;

   tsc_coordinator #(.TICK_CYCLES(TICKS), .NUM_PHASES(8)) dut (
      .REF_CLK(ref_clk), .RST_N(rst_n), .COORD_SEL(coord_sel), .PANEL_CYCLE(panel_cycle), .MASTER(master),
      .TOD_USE(tod_use), .TOD_CYCLE(tod_cycle), .TOD_OFFSET(tod_offset), .TOD_FREE(tod_free),
      .SPECIAL_OP(special_op), .PHASE_A_END(phase_a_end), .DWELL(dwell), .INTERRUPT_EN(interrupt_en),
      .INTERRUPT_SEC(interrupt_sec), .AUX_END_PCT(aux_end_pct), .PLAN_WR(plan_wr), .PLAN_WR_IDX(plan_wr_idx),
      .PLAN_WR_DATA(plan_data), .PERMIT_PCT(permit_pct), .PHASE_OMIT_CFG(omit_cfg), .AUX_CFG(aux_cfg),
      .OUTS(outs), .AUX_MOVE_END(aux_move_end), .PERMIT(permit), .PHASE_OMIT(phase_omit), .AUX_OUT(aux_out),
      .SYNC_LAMP(sync_lamp), .CYCLE_COUNT(cycle_count), .ACTIVE_CYCLE(active_cycle),
      .ACTIVE_OFFSET(active_offset), .IN_STEP(in_step), .ENTRY_ACK(entry_ack));

   tsc_ctrl_model ctrl (.clk(ref_clk), .rst_n(rst_n), .outs(outs), .yield_req(yield_req), .dwell_req(dwell_req),
      .phase_a_end(phase_a_end), .dwell(dwell), .internal_max_on(ctrl_max_on), .free_mode(ctrl_free));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic plan_put(input logic [1:0] idx, input tsc_pkg::tsc_plan_type d, input logic ack);
      @(posedge ref_clk);
      plan_wr <= 1'b1;
      plan_wr_idx <= idx;
      plan_data <= d;
      @(posedge ref_clk);
      plan_wr <= 1'b0;
      #1 chk(entry_ack, ack);
      tick(1);
      chk(entry_ack, 1'b0);
   endtask

   task automatic t_free();
      tick(2);
      chk(outs.free_run, 1'b1);
      chk(ctrl_max_on, 1'b1);
      $display("test free done");
   endtask

   task automatic t_plan();
      plan_put(2'h1, {8'h46, 7'h2d, 7'h05, 7'h00, 7'h19, 7'h63}, 1'b1);
      plan_put(2'h2, {8'h00, 7'h2d, 7'h05, 7'h00, 7'h19, 7'h63}, 1'b0);
      plan_put(2'h2, {8'h5a, 7'h65, 7'h05, 7'h00, 7'h19, 7'h63}, 1'b0);
      $display("test plan done");
   endtask

   task automatic t_timer();
      logic [7:0] c;
      int         n;
      @(posedge ref_clk);
      special_op <= 1'b1;
      tick(1);
      c = cycle_count;
      tick(TICKS);
      chk(cycle_count, (c == 8'h3b) ? 8'h00 : c + 8'h01);
      @(posedge ref_clk);
      special_op <= 1'b0;
      panel_cycle <= 2'h1;
      n = 0;
      while (cycle_count !== 8'h45 && n < 1500) begin
         tick(1);
         n++;
      end
      tick(TICKS);
      chk(cycle_count, 8'h00);
      $display("test timer done");
   endtask

   task automatic t_select();
      @(posedge ref_clk);
      master <= {2'h2, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0};
      tick(3);
      chk({active_cycle, active_offset}, 4'h9);
      @(posedge ref_clk);
      master.conflict <= 1'b1;
      tick(3);
      chk({active_cycle, active_offset}, 4'h0);
      @(posedge ref_clk);
      master <= '0;
      panel_cycle <= 2'h2;
      tick(3);
      @(posedge ref_clk);
      panel_cycle <= 2'h3;   // unused selector position is ignored
      tick(3);
      chk(active_cycle, 2'h2);
      @(posedge ref_clk);
      tod_use <= 1'b1;
      tod_cycle <= 2'h3;
      tod_offset <= 2'h2;
      tick(3);
      chk({active_cycle, active_offset}, 4'he);
      @(posedge ref_clk);
      tod_use <= 1'b0;
      panel_cycle <= 2'h0;
      $display("test select done");
   endtask

   task automatic t_coord();
      int n;
      @(posedge ref_clk);
      master <= {2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0};
      coord_sel <= 1'b1;
      tick(3);
      chk(outs.free_run, 1'b1);
      @(posedge ref_clk);
      yield_req <= 1'b1;
      @(posedge ref_clk);
      yield_req <= 1'b0;
      tick(4);
      chk(outs.free_run, 1'b0);
      chk(outs.max_inhibit, 1'b1);
      chk(sync_lamp, 3'h1);
      chk(phase_omit, omit_cfg);
      chk(permit, 1'b0);
      chk(aux_move_end, 1'b0);
      chk(aux_out, aux_cfg);
      chk(in_step, 1'b0);
      @(posedge ref_clk);
      interrupt_en <= 1'b1;
      interrupt_sec <= 6'h02;
      n = 0;
      while (outs.force_off !== 1'b0 && n < 1500) begin
         tick(1);
         n++;
      end
      @(posedge ref_clk);
      dwell_req <= 1'b1;
      n = 0;
      while (outs.force_off !== 1'b1 && n < 3 * TICKS + 4) begin
         tick(1);
         n++;
      end
      chk(outs.force_off, 1'b1);
      @(posedge ref_clk);
      dwell_req <= 1'b0;
      master.free_req <= 1'b1;
      tick(4);
      chk(outs.free_run, 1'b1);
      chk(ctrl_free, 1'b1);
      chk(sync_lamp, 3'h0);
      $display("test coord done");
   endtask

   initial begin
      {rst_n, coord_sel, tod_use, tod_free, special_op, yield_req, dwell_req, interrupt_en, plan_wr} = '0;
      {panel_cycle, tod_cycle, tod_offset, plan_wr_idx, interrupt_sec, permit_pct, aux_cfg} = '0;
      master = '0;
      plan_data = '0;
      aux_end_pct = 8'h80;
      omit_cfg = 8'ha5;
      repeat (5) @(posedge ref_clk);
      chk(outs, 8'h00);
      rst_n <= 1'b1;
      t_free();
      t_plan();
      t_timer();
      t_select();
      t_coord();
      results();
   end
endmodule
